// File: core/mod_divider.sv
// Modulo event divider: one output pulse per factor input ticks.
`timescale 1ns/100ps
module mod_divider #(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         enable,
  input  wire logic         tick,
  input  wire logic [W-1:0] factor,
  output logic              pulse
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } state_s;

  state_s       s;
  state_s       next_s;
  logic [W-1:0] eff;

  ////////////////////////////////////////////////////////////////////////////////
  assign eff = (factor == '0) ? W'(1) : factor;

  always_comb begin
    next_s       = s;
    next_s.pulse = 1'b0;
    if (!enable) begin
      next_s.cnt = '0;
    end else if (tick) begin
      if (s.cnt >= eff - W'(1)) begin
        next_s.cnt   = '0;
        next_s.pulse = 1'b1;
      end else begin
        next_s.cnt = s.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;

endmodule : mod_divider

// File: core/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/100ps
module pin_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } state_s;

  state_s s;
  state_s next_s;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s       = s;
    next_s.s1    = pinIn;
    next_s.s2    = s.s1;
    next_s.s3    = s.s2;
    next_s.rise  = 1'b0;
    // A change counts only once the second and third stages agree.
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
      next_s.rise  = s.s3 & ~s.level;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign rise  = s.rise;

endmodule : pin_sync

// File: core/pll_clock_generator_control.sv
// Digital control of the loop clock generator with its AHB-Lite register slave.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/100ps

// Functional notes
// - Base clock from exactly one of three sources.
// - Manual mode forces lock interrupt enable clear.
// - Manual mode reads lock flag and lock zero.
// - Auto mode makes tracking select read-only status.
// - Loop off or zero range clears source select.
// - Loop on locks the programming fields.
// - Loop source selected forces power on set.
// - Reference divided by modulo factor R.
// - VCO prescaled by 2^P, then modulo N.
// - Feedback multiplier spans 1 to 4095.
// - Phase detector emits direction-signed correction pulses.
// - Lock detector compares frequencies per reference period.
// - Tracking whenever tracking select reads one.
// - Auto mode switches acquisition and tracking automatically.
// - Lock indicator follows tolerance in auto mode.
// - Enabled lock toggle raises interrupt request.
// - Manual mode disables lock and interrupts.
// - Center code equals L times 2^E.
// - Zero R or N behaves as one.
// - Zero linear range disables loop, forces oscillator.
// - Switch holds output, waits three edges each.
// - Halve bypass passes oscillator clock straight through.
module pll_clock_generator_control (
  input  wire logic                                              sys_clk,
  input  wire logic                                              rst,
  input  wire logic                                              hsel,
  input  wire logic [pll_clock_generator_control_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                                        htrans,
  input  wire logic                                              hwrite,
  input  wire logic [2:0]                                        hsize,
  input  wire logic [pll_clock_generator_control_pkg::DATA_W-1:0] hwdata,
  input  wire logic                                              hready,
  output logic                                                   hreadyout,
  output logic [pll_clock_generator_control_pkg::DATA_W-1:0]      hrdata,
  output logic                                                   hresp,
  input  wire logic                                              oscClock,
  input  wire logic                                              loopRefClock,
  input  wire logic                                              vcoClock,
  output logic                                                   baseClockOut,
  output logic                                                   dividedVcoClock,
  output logic                                                   finalReferenceClock,
  output logic                                                   feedbackClock,
  output logic                                                   pumpUp,
  output logic                                                   pumpDown,
  output logic                                                   trackingMode,
  output logic                                                   loopEnable,
  output logic [pll_clock_generator_control_pkg::CENTER_W-1:0]    vcoCenterCode,
  output logic                                                   cpuIrq
);
  import pll_clock_generator_control_pkg::*;

  typedef struct packed {
    logic                lockIrqEnable;
    logic                lockChangeFlag;
    logic                loopPowerOn;
    logic                baseSourceSelect;
    logic [1:0]          prescale;
    logic [1:0]          rangeExp;
    logic                lockBandwidthAuto;
    logic                trackingSelect;
    logic [MULT_W-1:0]   feedbackMult;
    logic [RANGE_W-1:0]  vcoRangeFactor;
    logic [REFDIV_W-1:0] refDivide;
    logic                halveBypass;
    logic                dataWrite;
    logic [DEC_W-1:0]    dataAddr;
    logic [DATA_W-1:0]   rdata;
    logic                pumpUp;
    logic                pumpDown;
    logic [CNT_W-1:0]    refCnt;
    logic [CNT_W-1:0]    fbCnt;
    logic [CNT_W-1:0]    fbPeriod;
    logic                lockDet;
    logic                trackDet;
    sel_phase_e          selPhase;
    src_e                selCur;
    src_e                selPend;
    logic [1:0]          oldEdges;
    logic [1:0]          newEdges;
    logic                baseClk;
    logic                vcoHalf;
  } state_s;

  state_s s;
  state_s next_s;

  logic              oscLevel;
  logic              oscRise;
  logic              refRise;
  logic              vcoRise;
  logic              refPulse;
  logic              vcoDivPulse;
  logic              fbPulse;
  logic              loopOn;
  logic [PRE_W-1:0]  prescaleFactor;

  ////////////////////////////////////////////////////////////////////////////////
  // Every clock pin is sampled, so all loop events live in the bus clock domain.
  pin_sync oscSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (oscClock),
    .level   (oscLevel),
    .rise    (oscRise)
  );

  pin_sync refSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (loopRefClock),
    .level   (),
    .rise    (refRise)
  );

  pin_sync vcoSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (vcoClock),
    .level   (),
    .rise    (vcoRise)
  );

  ////////////////////////////////////////////////////////////////////////////////
  assign loopOn         = s.loopPowerOn && (s.vcoRangeFactor != '0);
  assign prescaleFactor = PRE_W'(4'h1 << s.prescale);

  mod_divider #(.W(REFDIV_W)) refDivider (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (loopOn),
    .tick    (refRise),
    .factor  (s.refDivide),
    .pulse   (refPulse)
  );

  mod_divider #(.W(PRE_W)) vcoPrescaler (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (loopOn),
    .tick    (vcoRise),
    .factor  (prescaleFactor),
    .pulse   (vcoDivPulse)
  );

  mod_divider #(.W(MULT_W)) fbDivider (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (loopOn),
    .tick    (vcoDivPulse),
    .factor  (s.feedbackMult),
    .pulse   (fbPulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic             accept;
    logic             lockToggle;
    logic [CNT_W-1:0] diff;
    logic             oldEdge;
    logic             newEdge;
    src_e             wanted;
    accept     = 1'b0;
    lockToggle = 1'b0;
    diff       = '0;
    oldEdge    = 1'b0;
    newEdge    = 1'b0;
    wanted     = SRC_OSC_HALF;
    next_s     = s;

    // Data phase of a write.
    if (s.dataWrite) begin
      case (s.dataAddr)
        CTRL_OFFSET: begin
          if (s.lockBandwidthAuto) begin
            next_s.lockIrqEnable = hwdata[CTRL_IE_BIT];
          end
          // Power and selection never change together: each sees the other's old value.
          next_s.baseSourceSelect = (s.loopPowerOn && s.vcoRangeFactor != '0) ?
                                    hwdata[CTRL_BSEL_BIT] : 1'b0;
          next_s.loopPowerOn = s.baseSourceSelect ? 1'b1 : hwdata[CTRL_PON_BIT];
          if (!s.loopPowerOn) begin
            next_s.prescale = hwdata[CTRL_PRE_LSB +: 2];
            next_s.rangeExp = hwdata[CTRL_EXP_LSB +: 2];
          end
        end
        BW_OFFSET: begin
          next_s.lockBandwidthAuto = hwdata[BW_AUTO_BIT];
          if (!s.lockBandwidthAuto) begin
            next_s.trackingSelect = hwdata[BW_TRK_BIT];
          end
        end
        MULT_OFFSET: begin
          if (!s.loopPowerOn) begin
            next_s.feedbackMult = hwdata[MULT_W-1:0];
          end
        end
        RANGE_OFFSET: begin
          if (!s.loopPowerOn) begin
            next_s.vcoRangeFactor = hwdata[RANGE_W-1:0];
          end
        end
        REFDIV_OFFSET: begin
          if (!s.loopPowerOn) begin
            next_s.refDivide = hwdata[REFDIV_W-1:0];
          end
        end
        CFG_OFFSET: begin
          next_s.halveBypass = hwdata[CFG_HALVE_BIT];
        end
        default: begin
        end
      endcase
    end

    if (!next_s.lockBandwidthAuto) begin
      next_s.lockIrqEnable = 1'b0;
    end
    if (!next_s.loopPowerOn || next_s.vcoRangeFactor == '0) begin
      next_s.baseSourceSelect = 1'b0;
    end
    if (next_s.baseSourceSelect) begin
      next_s.loopPowerOn = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phase-frequency detector: the leading clock opens its pump until the other arrives.
    if (!loopOn) begin
      next_s.pumpUp   = 1'b0;
      next_s.pumpDown = 1'b0;
    end else begin
      next_s.pumpUp   = s.pumpUp | refPulse;
      next_s.pumpDown = s.pumpDown | fbPulse;
      if (next_s.pumpUp && next_s.pumpDown) begin
        next_s.pumpUp   = 1'b0;
        next_s.pumpDown = 1'b0;
      end
    end

    // Lock detector: feedback period against reference period, judged per reference edge.
    if (!loopOn) begin
      next_s.refCnt   = '0;
      next_s.fbCnt    = '0;
      next_s.fbPeriod = '0;
      next_s.lockDet  = 1'b0;
      next_s.trackDet = 1'b0;
    end else begin
      if (s.refCnt != CNT_MAX) begin
        next_s.refCnt = s.refCnt + CNT_W'(1);
      end
      if (s.fbCnt != CNT_MAX) begin
        next_s.fbCnt = s.fbCnt + CNT_W'(1);
      end
      if (fbPulse) begin
        next_s.fbPeriod = s.fbCnt;
        next_s.fbCnt    = '0;
      end
      if (refPulse) begin
        next_s.refCnt = '0;
        diff = (s.refCnt > s.fbPeriod) ? s.refCnt - s.fbPeriod : s.fbPeriod - s.refCnt;
        next_s.lockDet  = (s.fbPeriod != '0) && (diff <= LOCK_TOL_CYCLES);
        next_s.trackDet = (s.fbPeriod != '0) && (diff <= TRACK_TOL_CYCLES);
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Base clock selector with glitch-free hand-over.
    if (s.baseSourceSelect) begin
      wanted = SRC_VCO_HALF;
    end else if (s.halveBypass) begin
      wanted = SRC_OSC_FULL;
    end else begin
      wanted = SRC_OSC_HALF;
    end
    if (vcoDivPulse) begin
      next_s.vcoHalf = ~s.vcoHalf;
    end
    oldEdge = (s.selCur == SRC_VCO_HALF) ? vcoDivPulse : oscRise;
    newEdge = (s.selPend == SRC_VCO_HALF) ? vcoDivPulse : oscRise;
    unique case (s.selPhase)
      SEL_RUN: begin
        if (wanted != s.selCur) begin
          next_s.selPhase = SEL_HOLD;
          next_s.selPend  = wanted;
          next_s.oldEdges = '0;
          next_s.newEdges = '0;
        end else begin
          unique case (s.selCur)
            SRC_OSC_FULL: next_s.baseClk = oscLevel;
            SRC_OSC_HALF: next_s.baseClk = oscRise ? ~s.baseClk : s.baseClk;
            SRC_VCO_HALF: next_s.baseClk = vcoDivPulse ? ~s.baseClk : s.baseClk;
            default:      next_s.baseClk = s.baseClk;
          endcase
        end
      end
      SEL_HOLD: begin
        // The output stays frozen until both clocks have shown their edges.
        if (oldEdge && s.oldEdges != SWITCH_EDGES) begin
          next_s.oldEdges = s.oldEdges + 2'h1;
        end
        if (newEdge && s.newEdges != SWITCH_EDGES) begin
          next_s.newEdges = s.newEdges + 2'h1;
        end
        if (s.oldEdges == SWITCH_EDGES && s.newEdges == SWITCH_EDGES) begin
          next_s.selCur   = s.selPend;
          next_s.selPhase = SEL_RUN;
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////////
    // Address phase; read data reflects any write finishing in this same cycle.
    accept           = hsel && hready && htrans[1];
    next_s.dataWrite = accept && hwrite;
    next_s.dataAddr  = haddr[DEC_W-1:0];
    if (accept && !hwrite) begin
      next_s.rdata = '0;
      case (haddr[DEC_W-1:0])
        CTRL_OFFSET: begin
          next_s.rdata[CTRL_IE_BIT]             = next_s.lockIrqEnable;
          next_s.rdata[CTRL_FLAG_BIT]           = next_s.lockChangeFlag &
                                                  next_s.lockBandwidthAuto;
          next_s.rdata[CTRL_PON_BIT]            = next_s.loopPowerOn;
          next_s.rdata[CTRL_BSEL_BIT]           = next_s.baseSourceSelect;
          next_s.rdata[CTRL_PRE_LSB +: 2]       = next_s.prescale;
          next_s.rdata[CTRL_EXP_LSB +: 2]       = next_s.rangeExp;
        end
        BW_OFFSET: begin
          next_s.rdata[BW_AUTO_BIT] = next_s.lockBandwidthAuto;
          next_s.rdata[BW_LOCK_BIT] = next_s.lockBandwidthAuto & next_s.lockDet;
          next_s.rdata[BW_TRK_BIT]  = next_s.lockBandwidthAuto ? next_s.trackDet :
                                      next_s.trackingSelect;
        end
        MULT_OFFSET:   next_s.rdata[MULT_W-1:0]   = next_s.feedbackMult;
        RANGE_OFFSET:  next_s.rdata[RANGE_W-1:0]  = next_s.vcoRangeFactor;
        REFDIV_OFFSET: next_s.rdata[REFDIV_W-1:0] = next_s.refDivide;
        CFG_OFFSET:    next_s.rdata[CFG_HALVE_BIT] = next_s.halveBypass;
        default: begin
        end
      endcase
      if (haddr[DEC_W-1:0] == CTRL_OFFSET) begin
        next_s.lockChangeFlag = 1'b0;
      end
    end

    // A lock change in the cycle of a clearing read still sets the flag.
    lockToggle = s.lockBandwidthAuto && (next_s.lockDet != s.lockDet);
    if (lockToggle) begin
      next_s.lockChangeFlag = 1'b1;
    end
    if (!next_s.lockBandwidthAuto) begin
      next_s.lockChangeFlag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s                <= '0;
      s.feedbackMult   <= MULT_RESET;
      s.vcoRangeFactor <= RANGE_RESET;
      s.refDivide      <= REFDIV_RESET;
      s.selPhase       <= SEL_RUN;
      s.selCur         <= SRC_OSC_HALF;
      s.selPend        <= SRC_OSC_HALF;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = s.rdata;
  assign baseClockOut        = s.baseClk;
  assign dividedVcoClock     = s.vcoHalf;
  assign finalReferenceClock = refPulse;
  assign feedbackClock       = fbPulse;
  assign pumpUp              = s.pumpUp;
  assign pumpDown            = s.pumpDown;
  assign trackingMode        = s.lockBandwidthAuto ? s.trackDet : s.trackingSelect;
  assign loopEnable          = loopOn;
  assign vcoCenterCode       = CENTER_W'({3'b000, s.vcoRangeFactor} << s.rangeExp);
  assign cpuIrq              = s.lockChangeFlag & s.lockIrqEnable &
                               s.lockBandwidthAuto;

endmodule : pll_clock_generator_control

// File: core/pll_clock_generator_control_pkg.sv
// Constants, register map and state encodings for the clock generator control block.
package pll_clock_generator_control_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 32;
  localparam int          DEC_W          = 8;
  localparam int          MULT_W         = 12;
  localparam int          RANGE_W        = 8;
  localparam int          REFDIV_W       = 4;
  localparam int          PRE_W          = 4;
  localparam int          CNT_W          = 16;
  localparam int          CENTER_W       = RANGE_W + 3;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [DEC_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [DEC_W-1:0] BW_OFFSET     = 8'h04;
  localparam logic [DEC_W-1:0] MULT_OFFSET   = 8'h08;
  localparam logic [DEC_W-1:0] RANGE_OFFSET  = 8'h0C;
  localparam logic [DEC_W-1:0] REFDIV_OFFSET = 8'h10;
  localparam logic [DEC_W-1:0] CFG_OFFSET    = 8'h14;

  localparam int CTRL_IE_BIT    = 7;
  localparam int CTRL_FLAG_BIT  = 6;
  localparam int CTRL_PON_BIT   = 5;
  localparam int CTRL_BSEL_BIT  = 4;
  localparam int CTRL_PRE_LSB   = 2;
  localparam int CTRL_EXP_LSB   = 0;
  localparam int BW_AUTO_BIT    = 7;
  localparam int BW_LOCK_BIT    = 6;
  localparam int BW_TRK_BIT     = 5;
  localparam int CFG_HALVE_BIT  = 0;

  localparam logic [MULT_W-1:0]   MULT_RESET   = 12'h001;
  localparam logic [RANGE_W-1:0]  RANGE_RESET  = 8'h00;
  localparam logic [REFDIV_W-1:0] REFDIV_RESET = 4'h1;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [CNT_W-1:0] LOCK_TOL_CYCLES  = 16'h0004;
  localparam logic [CNT_W-1:0] TRACK_TOL_CYCLES = 16'h0010;
  localparam logic [CNT_W-1:0] CNT_MAX          = 16'hFFFF;
  localparam logic [1:0]       SWITCH_EDGES     = 2'h3;

  typedef enum logic [1:0] {
    SRC_OSC_HALF = 2'b00,
    SRC_OSC_FULL = 2'b01,
    SRC_VCO_HALF = 2'b10
  } src_e;

  typedef enum logic {
    SEL_RUN  = 1'b0,
    SEL_HOLD = 1'b1
  } sel_phase_e;

endpackage : pll_clock_generator_control_pkg

// File: sim/clock_source_model.sv
// Oscillator, reference and VCO pin sources facing the block.
`timescale 1ns/100ps
module clock_source_model #(
  parameter realtime OSC_HALF = 100.0,
  parameter realtime VCO_HALF = 100.0
) (
  input  wire logic vcoRun,
  output logic      oscClock,
  output logic      loopRefClock,
  output logic      vcoClock
);
  initial oscClock = 1'b0;
  initial vcoClock = 1'b0;
  always #(OSC_HALF) oscClock = ~oscClock;
  // The reference pin is a buffered copy of the oscillator.
  assign loopRefClock = oscClock;
  // A powered-down VCO stands still low instead of holding its last level.
  always begin
    if (vcoRun === 1'b1 || vcoClock === 1'b1) #(VCO_HALF) vcoClock = ~vcoClock;
    else begin
      @(vcoRun);
      // Starting a little late keeps the pin's edges off the sampling edge.
      #5;
    end
  end
endmodule : clock_source_model

// File: sim/pll_clock_generator_control_checker.sv
// Port-level assertions for the clock generator control block.
`timescale 1ns/100ps
module pll_clock_generator_control_checker (
  input wire logic                                               sys_clk,
  input wire logic                                               rst,
  input wire logic                                               hreadyout,
  input wire logic                                               hresp,
  input wire logic                                               baseClockOut,
  input wire logic                                               dividedVcoClock,
  input wire logic                                               finalReferenceClock,
  input wire logic                                               feedbackClock,
  input wire logic                                               pumpUp,
  input wire logic                                               pumpDown,
  input wire logic                                               loopEnable,
  input wire logic [pll_clock_generator_control_pkg::CENTER_W-1:0] vcoCenterCode,
  input wire logic                                               cpuIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_pump_exclusive: assert property (!(pumpUp && pumpDown))
    else $error("both pump directions active");
  a_ref_single: assert property (finalReferenceClock |=> !finalReferenceClock)
    else $error("reference pulse longer than one cycle");
  a_fb_single: assert property (feedbackClock |=> !feedbackClock)
    else $error("feedback pulse longer than one cycle");
  a_div_vco_rate: assert property ($changed(dividedVcoClock) |=> $stable(dividedVcoClock))
    else $error("divided clock toggles too fast");
  a_base_rate: assert property ($changed(baseClockOut) |=> $stable(baseClockOut))
    else $error("base clock toggles too fast");
  a_center_loop: assert property (loopEnable |-> vcoCenterCode != '0)
    else $error("loop enabled with zero range");
  // Reset itself is watched here, so this one must not be disabled by it.
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !cpuIrq && !loopEnable)
    else $error("irq or loop active after reset");
endmodule : pll_clock_generator_control_checker

bind pll_clock_generator_control pll_clock_generator_control_checker chk (
  .sys_clk(sys_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .baseClockOut(baseClockOut), .dividedVcoClock(dividedVcoClock),
  .finalReferenceClock(finalReferenceClock), .feedbackClock(feedbackClock),
  .pumpUp(pumpUp), .pumpDown(pumpDown), .loopEnable(loopEnable),
  .vcoCenterCode(vcoCenterCode), .cpuIrq(cpuIrq));

// File: sim/pll_clock_generator_control_test.sv
// Register-level testbench for the clock generator control block.
`timescale 1ns/100ps
`define CHECK_EQ(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module pll_clock_generator_control_test;
  import pll_clock_generator_control_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic oscClock, loopRefClock, vcoClock, baseClockOut, dividedVcoClock;
  logic finalReferenceClock, feedbackClock, pumpUp, pumpDown, trackingMode, loopEnable, cpuIrq;
  logic [CENTER_W-1:0] vcoCenterCode;
  int mismatches = 0, cmp_count = 0, cnt;
  always #12.5 sys_clk = ~sys_clk;
  clock_source_model src (.vcoRun(loopEnable), .oscClock(oscClock),
    .loopRefClock(loopRefClock), .vcoClock(vcoClock));
  pll_clock_generator_control dut (.sys_clk(sys_clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .oscClock(oscClock),
    .loopRefClock(loopRefClock), .vcoClock(vcoClock), .baseClockOut(baseClockOut),
    .dividedVcoClock(dividedVcoClock), .finalReferenceClock(finalReferenceClock),
    .feedbackClock(feedbackClock), .pumpUp(pumpUp), .pumpDown(pumpDown),
    .trackingMode(trackingMode), .loopEnable(loopEnable), .vcoCenterCode(vcoCenterCode),
    .cpuIrq(cpuIrq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 100) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 100) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_ready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHECK_EQ(r, e)
  endtask : rdchk
  // Counting toggles over a fixed span tolerates the unknown pin-sync phase.
  task automatic toggles(output int c);
    logic last;
    c = 0;
    last = baseClockOut;
    repeat (400) begin
      @(posedge sys_clk);
      if (baseClockOut !== last) c++;
      last = baseClockOut;
    end
  endtask : toggles
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(CTRL_OFFSET, 32'h00); rdchk(MULT_OFFSET, 32'h001);
    rdchk(REFDIV_OFFSET, 32'h1); rdchk(8'h40, 32'h0);
    wr(CTRL_OFFSET, 32'h80); rdchk(CTRL_OFFSET, 32'h00);
    wr(CTRL_OFFSET, 32'h10); rdchk(CTRL_OFFSET, 32'h00);
    wr(CTRL_OFFSET, 32'h20); wr(CTRL_OFFSET, 32'h30); rdchk(CTRL_OFFSET, 32'h20);
    `CHECK_EQ(loopEnable, 1'b0)
    wr(MULT_OFFSET, 32'h5); rdchk(MULT_OFFSET, 32'h001);
    wr(CTRL_OFFSET, 32'h00); wr(MULT_OFFSET, 32'hFFF); rdchk(MULT_OFFSET, 32'hFFF);
    for (int e = 0; e < 3; e++) begin
      wr(CTRL_OFFSET, e); wr(RANGE_OFFSET, 32'h83);
      // The range lands at the edge that ends the write, so look one edge later.
      @(posedge sys_clk);
      `CHECK_EQ(vcoCenterCode, 11'h083 << e)
    end
    wr(BW_OFFSET, 32'h20); rdchk(BW_OFFSET, 32'h20);
    `CHECK_EQ(trackingMode, 1'b1)
    wr(BW_OFFSET, 32'h00); wr(CTRL_OFFSET, 32'h00);
    toggles(cnt); `CHECK_EQ(cnt inside {[45:55]}, 1'b1)
    wr(CFG_OFFSET, 32'h1);
    // The hand-over freezes the output for three edges of each source first.
    repeat (40) @(posedge sys_clk);
    toggles(cnt); `CHECK_EQ(cnt inside {[95:105]}, 1'b1)
    wr(CFG_OFFSET, 32'h0);
    // Crystal reference with R kept at 1 and the VCO at the reference rate.
    wr(RANGE_OFFSET, 32'h01); wr(MULT_OFFSET, 32'h1); wr(REFDIV_OFFSET, 32'h1);
    wr(BW_OFFSET, 32'h80); wr(CTRL_OFFSET, 32'hA0);
    cnt = 0;
    while (cpuIrq !== 1'b1 && cnt < 3000) begin
      cnt++;
      @(posedge sys_clk);
    end
    `CHECK_EQ(cpuIrq, 1'b1)
    if (cnt == 3000) wrap_up();
    rdchk(BW_OFFSET, 32'hE0);
    rdchk(CTRL_OFFSET, 32'hE0);
    `CHECK_EQ(cpuIrq, 1'b0)
    wr(BW_OFFSET, 32'h80); rdchk(BW_OFFSET, 32'hE0);
    wr(CTRL_OFFSET, 32'hB0); rdchk(CTRL_OFFSET, 32'hB0);
    wr(CTRL_OFFSET, 32'h80); rdchk(CTRL_OFFSET, 32'hA0);
    wr(BW_OFFSET, 32'h00); rdchk(BW_OFFSET, 32'h00);
    rdchk(CTRL_OFFSET, 32'h20);
    repeat (40) @(posedge sys_clk);
    wr(BW_OFFSET, 32'h20); rdchk(BW_OFFSET, 32'h20);
    `CHECK_EQ(trackingMode, 1'b1)
    `CHECK_EQ(cpuIrq, 1'b0)
    wrap_up();
  end
endmodule : pll_clock_generator_control_test
